/* File: core/hbs_regs.svh */
/*
 * constants of the host bus slave port: widths, sizes and reset values.
 * assumes inclusion by bare name from design files under core/.
 */
`ifndef HBS_REGS_SVH
`define HBS_REGS_SVH

// data bus width, address bus width
`define HBS_DATA_W 16
`define HBS_ADDR_W 8
// internal register store: 128 words of 16 bits = 256 byte addresses
`define HBS_WORDS 128
`define HBS_WADDR_W 7
// width of the synchroniser vector: 31 input pins and one constant bit
`define HBS_SYNC_W 32
// reset value of the synchronisers: strobes, selects and lanes idle high,
// bus style pin (bit 28) low so that no false falling edge is seen after reset
`define HBS_SYNC_RST 32'hefff_ffff
// bit position of the bus style pin in the synchroniser vector
`define HBS_SYNC_STYLE 28
// output enable pattern for an 8-bit read (low lane only)
`define HBS_OE_NARROW 16'h00ff
// read data reset value
`define HBS_DOUT_RST 16'h0000

`endif

/* File: core/hbs_pkg.sv */
/*
 * types of the host bus slave port.
 * assumes nothing of its surroundings.
 */
package hbs_pkg;

    // access sequencer states, one-hot
    typedef enum logic [3:0] {
        HBS_IDLE  = 4'b0001,
        HBS_ISSUE = 4'b0010,
        HBS_FETCH = 4'b0100,
        HBS_ACK   = 4'b1000
    } hbs_state_t;

    // byte lane set, bit 1 upper lane, bit 0 lower lane
    typedef logic [1:0] hbs_lanes_t;

endpackage

/* File: core/hbs_mem_if.sv */
/*
 * carrier between the port sequencer and the register store.
 * assumes both ends run on the same clock.
 */
`include "hbs_regs.svh"

interface hbs_mem_if;
    logic [`HBS_WADDR_W-1:0] addr; // word address
    logic wrEn; // write strobe, one cycle
    logic rdEn; // read strobe, one cycle
    logic [1:0] byteEn; // lane enables for writes
    logic [`HBS_DATA_W-1:0] wrData; // write data
    logic [`HBS_DATA_W-1:0] rdData; // registered read data

    // sequencer end
    modport ctrl (output addr, wrEn, rdEn, byteEn, wrData, input rdData);
    // store end
    modport store (input addr, wrEn, rdEn, byteEn, wrData, output rdData);
endinterface

/* File: core/hbs_reg_mem.sv */
/*
 * register store: 128 words of 16 bits with byte lane writes and
 * registered read data one cycle after the read strobe.
 * assumes one clock and an asynchronous active low reset.
 */
`include "hbs_regs.svh"

module hbs_reg_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // access port
    hbs_mem_if.store mem
);

    // ****************************************
    // storage
    // ****************************************
    // per-lane storage and write, one generate loop over the two lanes;
    // each lane array has a single writer
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gLane
            logic [7:0] laneMem [`HBS_WORDS]; // one byte lane of the store
            logic laneWr; // write this lane now
            assign laneWr = mem.wrEn & mem.byteEn[g];
            // lane write, no reset on the array
            always_ff @(posedge clk)
            begin
                if (laneWr)
                    laneMem[mem.addr] <= mem.wrData[8*g +: 8];
            end
        end
    endgenerate

    // registered read data
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mem.rdData <= `HBS_DOUT_RST;
        else if (mem.rdEn)
            mem.rdData <= {gLane[1].laneMem[mem.addr], gLane[0].laneMem[mem.addr]};
    end

endmodule

/* File: core/hbs_host_port.sv */
/*
 * host bus slave port: separate-strobe and data-strobe styles, 8 or 16 bit,
 * demultiplexed or multiplexed address, acknowledge handshake.
 * assumes an asynchronous host: every pin is synchronised to clk; the
 * board joins tri-state wires from the output enables.
 */
// Contract
// - sixteen tri-state data lines to host
// - eight address inputs select the register
// - lowest address pin is lsb in 8-bit
// - 16-bit separate: lowest pin is low enable
// - high enable selects upper lane, 16-bit only
// - 16-bit data-strobe: two lane strobes
// - 8-bit data-strobe: single data strobe
// - style pin high: data-strobe style
// - style pin low: separate-strobe style
// - style pin falling edge: multiplexed mode
// - address latched on latch strobe fall
// - read strobe: device drives register data
// - respond only while chip select low
// - write strobe: device stores host data
// - width pin low 8-bit, high 16-bit
// - acknowledge until strobe or select released
`include "hbs_regs.svh"

module hbs_host_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // address and data pins
    input wire logic [`HBS_ADDR_W-1:0] addrIn,
    input wire logic [`HBS_DATA_W-1:0] dataIn,
    output logic [`HBS_DATA_W-1:0] dataOut,
    output logic [`HBS_DATA_W-1:0] dataOe,
    // strobes and selects, all active low except rwSel, busStyleSelect and widthSel
    input wire logic chipSelect_n,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    input wire logic rwSel,
    input wire logic busStyleSelect,
    input wire logic widthSel,
    input wire logic laneStrobeHigh_n,
    // acknowledge, active low, tri-state when idle
    output logic transferAcknowledge_n,
    output logic transferAcknowledgeOe
);

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [`HBS_SYNC_W-1:0] syncRaw;
    logic [`HBS_SYNC_W-1:0] syncMeta; // read only by syncOut
    logic [`HBS_SYNC_W-1:0] syncOut;
    assign syncRaw = {1'b1, laneStrobeHigh_n, widthSel, busStyleSelect, rwSel,
                      writeStrobe_n, readStrobe_n, chipSelect_n, dataIn, addrIn};

    // two flip-flops per pin
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncMeta <= `HBS_SYNC_RST;
            syncOut <= `HBS_SYNC_RST;
        end
        else
        begin
            syncMeta <= syncRaw;
            syncOut <= syncMeta;
        end
    end

    // named synchronised pins
    wire [7:0] addrS = syncOut[7:0];
    wire [15:0] dinS = syncOut[23:8];
    wire csS_n = syncOut[24];
    wire rdS_n = syncOut[25];
    wire wrS_n = syncOut[26];
    wire rwS = syncOut[27];
    wire styleS = syncOut[`HBS_SYNC_STYLE];
    wire wideS = syncOut[29];
    wire laneStrobeHighS_n = syncOut[30];
    wire lowestAddressBit = addrS[0]; // shared with low enable / upper strobe

    // ****************************************
    // bus style and address latch
    // ****************************************
    logic styleLast; // previous style pin level
    logic muxMode; // sticky multiplexed mode
    logic [7:0] latchAddr; // latched multiplexed address
    wire styleFall = styleLast & ~styleS;

    // style pin edge detect, mode and address latch
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            styleLast <= 1'b0;
            muxMode <= 1'b0;
            latchAddr <= 8'h00;
        end
        else
        begin
            styleLast <= styleS;
            if (styleFall)
            begin
                muxMode <= 1'b1;
                latchAddr <= addrS;
            end
        end
    end

    // ****************************************
    // access decode
    // ****************************************
    wire sepStyle = muxMode | ~styleS;
    wire [7:0] byteAddr = muxMode ? latchAddr : addrS;
    // separate style lanes: low enable on shared address pin, high enable on lane pin
    wire [1:0] sepLanes = {~laneStrobeHighS_n, ~lowestAddressBit};
    // data-strobe style lanes: upper strobe on shared address pin, lower on lane pin
    wire [1:0] stbLanes = {~lowestAddressBit, ~laneStrobeHighS_n};
    wire [1:0] wideLanes = sepStyle ? sepLanes : stbLanes;
    // 8-bit: lsb picks the internal lane
    wire [1:0] narrowLanes = byteAddr[0] ? 2'h2 : 2'h1;
    wire [1:0] reqLanesNow = wideS ? wideLanes : narrowLanes;
    wire stbActive = wideS ? |stbLanes : ~laneStrobeHighS_n;
    wire rdReq = sepStyle ? ~rdS_n : (stbActive & rwS);
    wire wrReq = sepStyle ? ~wrS_n : (stbActive & ~rwS);
    wire laneOk = |reqLanesNow;
    wire accessNow = ~csS_n & (rdReq | wrReq) & laneOk;

    // ****************************************
    // access sequencer
    // ****************************************
    hbs_pkg::hbs_state_t state;
    hbs_pkg::hbs_state_t next_state;
    logic reqRead; // captured direction
    logic reqWide; // captured width
    logic [1:0] reqLanes; // captured lanes
    logic [6:0] reqWord; // captured word address
    hbs_mem_if memIf ();

    // next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            hbs_pkg::HBS_IDLE:
                if (accessNow)
                    next_state = hbs_pkg::HBS_ISSUE;
            hbs_pkg::HBS_ISSUE:
                next_state = hbs_pkg::HBS_FETCH;
            hbs_pkg::HBS_FETCH:
                next_state = hbs_pkg::HBS_ACK;
            hbs_pkg::HBS_ACK:
                if (!accessNow)
                    next_state = hbs_pkg::HBS_IDLE;
        endcase
    end

    // state and request capture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= hbs_pkg::HBS_IDLE;
            reqRead <= 1'b0;
            reqWide <= 1'b0;
            reqLanes <= 2'h0;
            reqWord <= 7'h00;
        end
        else
        begin
            state <= next_state;
            if (state == hbs_pkg::HBS_IDLE && accessNow)
            begin
                reqRead <= rdReq;
                reqWide <= wideS;
                reqLanes <= reqLanesNow;
                reqWord <= byteAddr[7:1];
            end
        end
    end

    wire stIssue = (state == hbs_pkg::HBS_ISSUE);
    wire stFetch = (state == hbs_pkg::HBS_FETCH);
    wire stAck = (state == hbs_pkg::HBS_ACK);

    // register store access
    assign memIf.addr = reqWord;
    assign memIf.rdEn = stIssue & reqRead;
    assign memIf.wrEn = stIssue & ~reqRead;
    assign memIf.byteEn = reqLanes;
    assign memIf.wrData = reqWide ? dinS : {dinS[7:0], dinS[7:0]};

    hbs_reg_mem hbs_reg_mem_inst (
        .clk(clk),
        .rst_n(rst_n),
        .mem(memIf)
    );

    // ****************************************
    // read data and pin drivers
    // ****************************************
    wire [15:0] laneMask = {{8{reqLanes[1]}}, {8{reqLanes[0]}}};
    wire [15:0] narrowByte = {8'h00, reqLanes[1] ? memIf.rdData[15:8] : memIf.rdData[7:0]};
    wire [15:0] readWord = reqWide ? (memIf.rdData & laneMask) : narrowByte;

    // read data register loaded one cycle after the store read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dataOut <= `HBS_DOUT_RST;
        else if (stFetch)
            dataOut <= readWord;
    end

    wire driveRead = stAck & reqRead;
    wire [15:0] oePattern = reqWide ? laneMask : `HBS_OE_NARROW;
    assign dataOe = driveRead ? oePattern : 16'h0000;
    assign transferAcknowledge_n = ~stAck;
    assign transferAcknowledgeOe = stAck;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // drive may outlast the synchronised select release by one cycle only
    data_drive_read_a: assert property (|dataOe |-> driveRead && !$past(csS_n))
        else $error("data lines driven outside a read");
    ack_in_time_a: assert property (
        (state == hbs_pkg::HBS_IDLE) && accessNow |-> ##3 transferAcknowledgeOe)
        else $error("acknowledge not given three cycles after request");
    ack_release_a: assert property (stAck && !accessNow |=> !transferAcknowledgeOe)
        else $error("acknowledge held after release");
    select_gate_a: assert property (stIssue |-> !$past(csS_n))
        else $error("access started without chip select");
    mux_sticky_a: assert property (styleFall |=> muxMode [*3])
        else $error("multiplexed mode not entered or lost");
    addr_latch_a: assert property (styleFall |=> latchAddr == $past(addrS))
        else $error("address not latched on strobe fall");
    narrow_lane_a: assert property (driveRead && !reqWide |-> dataOe == 16'h00ff)
        else $error("8-bit read not on low lane");
    write_store_a: assert property (
        stIssue && !reqRead |-> memIf.wrEn && memIf.byteEn == reqLanes)
        else $error("write not passed to store");
    read_data_a: assert property (
        stFetch && reqRead && reqWide |=> dataOut == ($past(memIf.rdData) & laneMask))
        else $error("read word not presented");

    cover_read_c: cover property (driveRead && reqWide);
    cover_write_c: cover property (memIf.wrEn && !reqWide);
    cover_mux_c: cover property (muxMode && stAck);

endmodule

/* File: sim/hbs_host_model.sv */
/*
 * host processor model: one register access at a time on the port pins.
 * assumes the bench supplies clock and reset and calls the tasks in turn.
 */
module hbs_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // device outputs
    input wire logic [15:0] dataOut,
    input wire logic [15:0] dataOe,
    input wire logic transferAcknowledge_n,
    input wire logic transferAcknowledgeOe,
    // pins toward the device
    output logic [7:0] addrIn,
    output logic [15:0] dataIn,
    output logic chipSelect_n,
    output logic readStrobe_n,
    output logic writeStrobe_n,
    output logic rwSel,
    output logic busStyleSelect,
    output logic widthSel,
    output logic laneStrobeHigh_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // wires and idle
    // ****************
    logic [15:0] drv; // host drive, inverted once the host lets go
    logic [7:0] addrDrv; // address pins when not multiplexed
    logic mux; // address pins tied to the data wire
    logic adShift; // 8-bit part on a 16-bit multiplexed bus: address on lines 8..1
    logic ackW; // acknowledge wire, pulled up while not driven
    assign ackW = transferAcknowledgeOe ? transferAcknowledge_n : 1'h1;
    // device lanes win where enabled
    assign dataIn = (dataOut & dataOe) | (drv & ~dataOe);
    assign addrIn = !mux ? addrDrv : (adShift ? dataIn[8:1] : dataIn[7:0]);
    initial
    begin
        {chipSelect_n, readStrobe_n, writeStrobe_n, rwSel, laneStrobeHigh_n} = 5'h1f;
        {busStyleSelect, widthSel, mux, adShift} = 4'h0;
        drv = 16'h0000;
        addrDrv = 8'hff;
    end
    // board wiring back to demultiplexed on reset
    always @(negedge rst_n)
        mux = 1'h0;
    // ****************
    // one access; ctl is {select_n, style, width, read}
    // ****************
    task automatic acc(input logic [3:0] ctl, input logic [1:0] ln, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] rdv, oev, output logic got, rel);
        got = 1'h0;
        rel = 1'h1;
        @(negedge clk);
        // style pin static, settled before the access
        if (busStyleSelect !== ctl[2])
        begin
            busStyleSelect = ctl[2];
            repeat (4) @(negedge clk);
        end
        widthSel = ctl[1];
        rwSel = ctl[0]; // valid through the strobe
        drv = ctl[0] ? ~drv : d;
        addrDrv = a;
        if (ctl[1])
            addrDrv[0] = ctl[2] ? ~ln[1] : ~ln[0];
        laneStrobeHigh_n = ctl[2] ? (ctl[1] ? ~ln[0] : 1'h0) : ~ln[1];
        chipSelect_n = ctl[3];
        readStrobe_n = ctl[2] | ~ctl[0];
        writeStrobe_n = ctl[2] | ctl[0];
        for (int i = 0; i < 12 && !got; i++)
        begin
            @(negedge clk);
            got = (ackW === 1'h0);
            rdv = dataIn;
            oev = dataOe;
        end
        // strobe held a while after the answer
        repeat (2) @(negedge clk);
        if (got && ackW !== 1'h0)
            rel = 1'h0;
        {chipSelect_n, readStrobe_n, writeStrobe_n, laneStrobeHigh_n} = 4'hf;
        addrDrv[0] = 1'h1;
        drv = ~drv;
        for (int i = 0; i < 6 && (transferAcknowledgeOe || dataOe != 16'h0000); i++)
            @(negedge clk);
        if (transferAcknowledgeOe !== 1'h0 || dataOe !== 16'h0000)
            rel = 1'h0;
    endtask
    // address latch pulse on the style pin
    task automatic ale(input logic [7:0] a, input logic shifted);
        @(negedge clk);
        mux = 1'h1;
        adShift = shifted;
        drv = shifted ? {7'h00, a, 1'h0} : {8'h00, a};
        busStyleSelect = 1'h1;
        repeat (3) @(negedge clk);
        busStyleSelect = 1'h0;
        repeat (3) @(negedge clk);
    endtask
endmodule

/* File: sim/test_host_bus_slave_port.sv */
/*
 * bench of the host bus slave port: table of accesses and refusals, then
 * multiplexed mode and a second reset. assumes the core files and the host model.
 */
module test_host_bus_slave_port;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // rows: ctl {select_n, style, width, read}, lanes, address, data, enables, ack
    // ****************
    typedef struct {
        logic [3:0] ctl;
        logic [1:0] ln;
        logic [7:0] a;
        logic [15:0] d;
        logic [15:0] oe;
        logic ack;
    } hbs_row_t;
    hbs_row_t rows [16] = '{
        '{4'h0, 2'h1, 8'h10, 16'h005a, 16'h0000, 1'h1},
        '{4'h0, 2'h3, 8'h11, 16'h00c3, 16'h0000, 1'h1},
        '{4'ha, 2'h3, 8'h10, 16'hffff, 16'h0000, 1'h0},
        '{4'h3, 2'h0, 8'h10, 16'h0000, 16'h0000, 1'h0},
        '{4'h3, 2'h3, 8'h10, 16'hc35a, 16'hffff, 1'h1},
        '{4'h2, 2'h2, 8'h20, 16'hbe00, 16'h0000, 1'h1},
        '{4'h2, 2'h1, 8'h20, 16'h00ef, 16'h0000, 1'h1},
        '{4'h1, 2'h1, 8'h21, 16'h00be, 16'h00ff, 1'h1},
        '{4'h3, 2'h2, 8'h11, 16'hc300, 16'hff00, 1'h1},
        '{4'h7, 2'h1, 8'h20, 16'h00ef, 16'h00ff, 1'h1},
        '{4'h4, 2'h0, 8'h31, 16'h0077, 16'h0000, 1'h1},
        '{4'h6, 2'h3, 8'h40, 16'h1234, 16'h0000, 1'h1},
        '{4'h5, 2'h0, 8'h41, 16'h0012, 16'h00ff, 1'h1},
        '{4'h7, 2'h2, 8'h30, 16'h7700, 16'hff00, 1'h1},
        '{4'h7, 2'h0, 8'h30, 16'h0000, 16'h0000, 1'h0},
        '{4'hf, 2'h3, 8'h40, 16'h0000, 16'h0000, 1'h0}};
    logic clk, rst_n, chipSelect_n, readStrobe_n, writeStrobe_n, rwSel;
    logic busStyleSelect, widthSel, laneStrobeHigh_n;
    logic transferAcknowledge_n, transferAcknowledgeOe;
    logic [7:0] addrIn;
    logic [15:0] dataIn, dataOut, dataOe;
    int n_mismatch = 0;
    int checks = 0;
    hbs_host_port hbs_host_port_inst (.clk, .rst_n, .addrIn, .dataIn, .dataOut, .dataOe,
        .chipSelect_n, .readStrobe_n, .writeStrobe_n, .rwSel, .busStyleSelect, .widthSel,
        .laneStrobeHigh_n, .transferAcknowledge_n, .transferAcknowledgeOe);
    hbs_host_model hbs_host_model_inst (.clk, .rst_n, .dataOut, .dataOe,
        .transferAcknowledge_n, .transferAcknowledgeOe, .addrIn, .dataIn, .chipSelect_n,
        .readStrobe_n, .writeStrobe_n, .rwSel, .busStyleSelect, .widthSel, .laneStrobeHigh_n);
    // ****************
    // compare, verdict, one access
    // ****************
    task automatic check(input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic run(input hbs_row_t r);
        logic [15:0] rdv, oev;
        logic got, rel;
        hbs_host_model_inst.acc(r.ctl, r.ln, r.a, r.d, rdv, oev, got, rel);
        check({15'h0000, got}, {15'h0000, r.ack});
        // a lost answer ends the run
        if (got !== r.ack)
            test_done();
        else
        begin
            check({15'h0000, rel}, 16'h0001);
            check(oev, r.oe);
            if (r.ctl[0])
                check(rdv & r.oe, r.d);
        end
    endtask
    // clock, 100 ns period
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // ****************
    // main sequence
    // ****************
    initial
    begin
        rst_n = 1'h0;
        repeat (11) @(negedge clk);
        check(dataOe, 16'h0000);
        check({15'h0000, transferAcknowledgeOe}, 16'h0000);
        @(negedge clk);
        rst_n = 1'h1;
        foreach (rows[i])
            run(rows[i]);
        // multiplexed: latched address holds while data shares the lines
        hbs_host_model_inst.ale(8'h50, 1'h0);
        run('{4'h0, 2'h1, 8'h00, 16'h0066, 16'h0000, 1'h1});
        hbs_host_model_inst.ale(8'h31, 1'h1);
        run('{4'h1, 2'h1, 8'h00, 16'h0077, 16'h00ff, 1'h1});
        hbs_host_model_inst.ale(8'h50, 1'h0);
        run('{4'h1, 2'h1, 8'h00, 16'h0066, 16'h00ff, 1'h1});
        // second reset: pins quiet, demultiplexed wiring again
        @(negedge clk);
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        check(dataOe, 16'h0000);
        check({15'h0000, transferAcknowledgeOe}, 16'h0000);
        rst_n = 1'h1;
        run('{4'h0, 2'h1, 8'h60, 16'h0099, 16'h0000, 1'h1});
        run('{4'h0, 2'h1, 8'h61, 16'h00aa, 16'h0000, 1'h1});
        run('{4'h3, 2'h3, 8'h60, 16'haa99, 16'hffff, 1'h1});
        test_done();
    end
endmodule
